// ==== adc_ctrl_map.vh ====
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
// register offsets (word index on the plain port)
`define OFS_CONTROL 4'h0
`define OFS_REF_PIN 4'h1
`define OFS_CLK_FMT 4'h2
`define OFS_RESULT_HIGH 4'h3
`define OFS_RESULT_LOW 4'h4
`define OFS_IRQ_STATUS 4'h5
`define OFS_IRQ_ENABLE 4'h6
`define OFS_IRQ_CLEAR 4'h7
// reset values
`define RST_CONTROL 8'h00
`define RST_REF_PIN 8'h00
`define RST_CLK_FMT 8'h00
// control register fields
`define CTL_ON_BIT 0
`define CTL_GO_BIT 1
`define CTL_CHAN_LSB 2
// reference / pin register fields
`define REF_SEL_LSB 4
`define PIN_SEL_LSB 0
`define REF_PIN_MASK 8'h3F
// clock / format register fields
`define FMT_JUSTIFY_BIT 7
`define CLK_FMT_MASK 8'h87
// conversion timing
`define CONV_STEPS 4'hC
`define RC_CLOCK_NS 1000
`define SYS_CLOCK_NS 10
`define RC_DIV_CYCLES ((`RC_CLOCK_NS + `SYS_CLOCK_NS - 1) / `SYS_CLOCK_NS)
// rc period as a sized divider limit
`define RC_DIV_LIMIT 8'h64
`endif

// ==== adc_bit_clock.v ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
// conversion bit clock: one-cycle tick per conversion bit period
module adc_bit_clock (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // control
  input wire run,
  input wire [2:0] conversion_clock_select,
  input wire sleeping,
  // tick out
  output reg tick_q
);
  reg [7:0] count_q;
  reg [7:0] limit_d;
  reg rc_sel;
  // divisor decode; rc codes use slow internal oscillator period
  always @*
  begin
    rc_sel = 1'b0;
    case (conversion_clock_select)
      3'h0: limit_d = 8'h02;
      3'h1: limit_d = 8'h08;
      3'h2: limit_d = 8'h20;
      3'h4: limit_d = 8'h04;
      3'h5: limit_d = 8'h10;
      3'h6: limit_d = 8'h40;
      default:
      begin
        rc_sel = 1'b1;
        limit_d = `RC_DIV_LIMIT;
      end
    endcase
  end
  // counter; oscillator-derived clocks stop in sleep
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (!run || (sleeping && !rc_sel))
    begin
      if (!run)
        count_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (count_q >= limit_d - 8'h01)
    begin
      count_q <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
endmodule // adc_bit_clock
`default_nettype wire

// ==== adc_config_and_sequencer.v ====
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
// Overview of operation
// - reference/pin register top two bits read zero
// - two-bit field selects converter reference sources
// - pin field decodes analog/digital for sixteen inputs
// - only RC clock keeps converting during sleep
// - successive approximation, one bit per step
// - reset zeroes controls, aborts conversion, keeps result
// - completion loads result, clears go, sets flag
// - software sets go; hardware clears when done
// - converter-on low forbids any conversion
// - four-bit channel field selects input zero-fifteen
// - conversion lasts twelve bit periods
module adc_config_and_sequencer (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_q,
  // chip state
  input wire sleep_req,
  // analog core
  input wire compare_high,
  output reg [3:0] channel_select_q,
  output reg [9:0] trial_code_q,
  output reg sample_hold_q,
  output reg [1:0] reference_select_q,
  output reg [15:0] pin_analog_q,
  // interrupt
  output reg irq_q
);
  // ************************************************************
  // register state
  // ************************************************************
  // software-visible fields and sleep synchroniser stages
  reg converter_on_q;
  reg go_q;
  reg [5:0] ref_pin_q;
  reg result_justify_q;
  reg [2:0] conversion_clock_select_q;
  reg [9:0] result_q;
  reg conversion_done_flag_q;
  reg irq_enable_q;
  reg sleep_meta_q;
  reg sleep_q;
  // conversion progress
  reg [3:0] step_q;
  reg [3:0] bit_idx_q;
  reg busy_q;
  wire tick;
  wire done_evt;
  wire wr_ctl;
  wire go_set;
  // write strobes and read path
  wire wr_ref;
  wire wr_clk;
  wire wr_ien;
  wire wr_clr;
  wire [15:0] result_word;
  reg [7:0] reg_rdata_d;

  // one-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_CONVERT = 3'b100;
  // sequencer state register and its next value
  reg [2:0] state_q;
  reg [2:0] state_d;

  // analog/digital decode: nonzero code n makes top n+1 inputs digital; code zero leaves all analog
  function [15:0] pin_decode;
    input [3:0] code;
    integer k;
    begin
      pin_decode = 16'hFFFF;
      for (k = 0; k < 16; k = k + 1)
        if (code != 4'h0 && k >= 15 - code)
          pin_decode[k] = 1'b0;
      if (code == 4'hF)
        pin_decode = 16'h0000;
    end
  endfunction

  // justified result halves
  function [15:0] justify;
    input right;
    input [9:0] value;
    begin
      if (right)
        justify = {6'h00, value};
      else
        justify = {value, 6'h00};
    end
  endfunction

  // write strobe hit on one register index
  function reg_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] index;
    begin
      reg_hit = strobe && (addr == index);
    end
  endfunction

  // per-register write strobes and justified result
  assign wr_ctl = reg_hit(reg_write, reg_addr, `OFS_CONTROL);
  assign wr_ref = reg_hit(reg_write, reg_addr, `OFS_REF_PIN);
  assign wr_clk = reg_hit(reg_write, reg_addr, `OFS_CLK_FMT);
  assign wr_ien = reg_hit(reg_write, reg_addr, `OFS_IRQ_ENABLE);
  assign wr_clr = reg_hit(reg_write, reg_addr, `OFS_IRQ_CLEAR);
  assign result_word = justify(result_justify_q, result_q);
  assign go_set = wr_ctl && reg_wdata[`CTL_GO_BIT] && reg_wdata[`CTL_ON_BIT];
  assign done_evt = (state_q == ST_CONVERT) && tick && (step_q == `CONV_STEPS - 4'h1);

  // ************************************************************
  // sleep input synchroniser
  // ************************************************************
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleep_meta_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      sleep_meta_q <= sleep_req;
      sleep_q <= sleep_meta_q;
    end
  end

  // ************************************************************
  // bit clock
  // ************************************************************
  // ticks once per bit period; pauses in sleep unless on internal rc
  adc_bit_clock u_bit_clock (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(busy_q),
    .conversion_clock_select(conversion_clock_select_q),
    .sleeping(sleep_q),
    .tick_q(tick)
  );

  // ************************************************************
  // register writes
  // ************************************************************
  // control register: converter on and channel field
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      converter_on_q <= 1'b0;
      channel_select_q <= 4'h0;
    end
    else if (wr_ctl)
    begin
      converter_on_q <= reg_wdata[`CTL_ON_BIT];
      channel_select_q <= reg_wdata[`CTL_CHAN_LSB +: 4];
    end
  end

  // go flag: set by software, cleared at completion, at switch-off or by writing it low while idle
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      go_q <= 1'b0;
    else if (done_evt)
      go_q <= 1'b0;
    else if (go_set)
      go_q <= 1'b1;
    else if (!converter_on_q)
      go_q <= 1'b0;
    else if (wr_ctl && !reg_wdata[`CTL_GO_BIT] && !busy_q)
      go_q <= 1'b0; // writing go low while busy is ignored
  end

  // reference/pin register; top two bits are not stored
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ref_pin_q <= 6'h00;
    else if (wr_ref)
      ref_pin_q <= reg_wdata[5:0];
  end

  // clock/format register; bits six to three are not stored
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_justify_q <= 1'b0;
      conversion_clock_select_q <= 3'h0;
    end
    else if (wr_clk)
    begin
      result_justify_q <= reg_wdata[`FMT_JUSTIFY_BIT];
      conversion_clock_select_q <= reg_wdata[2:0];
    end
  end

  // interrupt enable register
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_enable_q <= 1'b0;
    else if (wr_ien)
      irq_enable_q <= reg_wdata[0];
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // next state; switching off returns to idle at once
  always @*
  begin
    case (state_q)
      ST_IDLE: state_d = (go_q && converter_on_q) ? ST_SAMPLE : ST_IDLE;
      ST_SAMPLE: state_d = ST_CONVERT;
      ST_CONVERT: state_d = done_evt ? ST_IDLE : ST_CONVERT;
      default: state_d = ST_IDLE;
    endcase
    if (!converter_on_q)
      state_d = ST_IDLE;
  end

  // approximation and step counting
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
      bit_idx_q <= 4'h9;
      busy_q <= 1'b0;
      trial_code_q <= 10'h000;
      sample_hold_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= (state_d != ST_IDLE);
      sample_hold_q <= (state_d == ST_CONVERT);
      if (state_d == ST_SAMPLE)
      begin
        step_q <= 4'h0;
        bit_idx_q <= 4'h9;
        trial_code_q <= 10'h200;
      end
      else if (state_q == ST_CONVERT && tick)
      begin
        step_q <= step_q + 4'h1;
        // steps 1..10 resolve bits msb first
        if (step_q >= 4'h1 && step_q <= 4'hA)
        begin
          if (!compare_high)
            trial_code_q[bit_idx_q] <= 1'b0;
          if (bit_idx_q != 4'h0)
          begin
            trial_code_q[bit_idx_q - 4'h1] <= 1'b1;
            bit_idx_q <= bit_idx_q - 4'h1;
          end
        end
      end
    end
  end

  // conversion result; no reset, so a reset leaves the last result readable
  always @(posedge ref_clk)
  begin
    if (done_evt)
      result_q <= trial_code_q;
  end

  // ************************************************************
  // interrupt status, enable and clear
  // ************************************************************
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conversion_done_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      // set wins over clear
      if (done_evt)
        conversion_done_flag_q <= 1'b1;
      else if (wr_clr && reg_wdata[0])
        conversion_done_flag_q <= 1'b0;
      irq_q <= (conversion_done_flag_q || done_evt) && irq_enable_q;
    end
  end

  // ************************************************************
  // analog core outputs and read port
  // ************************************************************
  // registered analog-core controls and read data
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reference_select_q <= 2'h0;
      pin_analog_q <= 16'hFFFF;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      reference_select_q <= ref_pin_q[`REF_SEL_LSB +: 2];
      pin_analog_q <= pin_decode(ref_pin_q[`PIN_SEL_LSB +: 4]);
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // read data select; zero unless a read strobe is present
  always @*
  begin
    reg_rdata_d = 8'h00;
    if (reg_read)
    begin
      case (reg_addr)
        `OFS_CONTROL: reg_rdata_d = {2'h0, channel_select_q, go_q, converter_on_q};
        `OFS_REF_PIN: reg_rdata_d = {2'h0, ref_pin_q};
        `OFS_CLK_FMT: reg_rdata_d = {result_justify_q, 4'h0, conversion_clock_select_q};
        `OFS_RESULT_HIGH: reg_rdata_d = result_word[15:8];
        `OFS_RESULT_LOW: reg_rdata_d = result_word[7:0];
        `OFS_IRQ_STATUS: reg_rdata_d = {7'h00, conversion_done_flag_q};
        `OFS_IRQ_ENABLE: reg_rdata_d = {7'h00, irq_enable_q};
        default: reg_rdata_d = 8'h00;
      endcase
    end
  end
endmodule // adc_config_and_sequencer
`default_nettype wire

// ==== adc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
// ************
// port checker
// ************
module adc_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata_q,
  // analog core
  input wire logic [3:0] channel_select_q,
  input wire logic [9:0] trial_code_q,
  input wire logic sample_hold_q,
  input wire logic [1:0] reference_select_q,
  input wire logic [15:0] pin_analog_q,
  input wire logic irq_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // write decodes
  wire wr_ref = reg_write && reg_addr == `OFS_REF_PIN;
  wire wr_ctl = reg_write && reg_addr == `OFS_CONTROL;
  // analog mask for a pin code
  function automatic logic [15:0] pmask(input logic [3:0] c);
    return (c == 4'h0) ? 16'hFFFF : 16'hFFFF >> (c + 5'h01);
  endfunction
  AST_REF_TOP: assert property (reg_read && reg_addr == `OFS_REF_PIN |=>
    reg_rdata_q[7:6] == 2'h0) else $error("ref/pin top bits set");
  AST_CLK_GAP: assert property (reg_read && reg_addr == `OFS_CLK_FMT |=>
    reg_rdata_q[6:3] == 4'h0) else $error("clk/fmt gap bits set");
  AST_REF_SEL: assert property (wr_ref |-> ##2
    reference_select_q == $past(reg_wdata[5:4], 2)) else $error("reference select wrong");
  AST_PIN_MAP: assert property (wr_ref |-> ##2
    pin_analog_q == pmask($past(reg_wdata[3:0], 2))) else $error("pin map wrong");
  AST_CHAN: assert property (wr_ctl && !sample_hold_q |=>
    channel_select_q == $past(reg_wdata[5:2])) else $error("channel wrong");
  AST_OFF: assert property (wr_ctl && !reg_wdata[0] |-> ##2 !sample_hold_q)
    else $error("hold while off");
  AST_SAR_START: assert property ($rose(sample_hold_q) |-> trial_code_q == 10'h200)
    else $error("first trial not midscale");
  AST_RST_CLR: assert property ($rose(reset_n) |-> !sample_hold_q && !irq_q
    && reference_select_q == 2'h0) else $error("reset state wrong");
endmodule // adc_chk
bind adc_config_and_sequencer adc_chk adc_chk_inst (.*);
`default_nettype wire

// ==== adc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************
// analog core model
// ******************
module adc_core_model (
  // clock
  input wire logic ref_clk,
  // from converter
  input wire logic [3:0] channel_select_q,
  input wire logic [9:0] trial_code_q,
  input wire logic sample_hold_q,
  // to converter
  output logic compare_high
);
  logic junk_q = 1'b0;
  // held level: channel number in the top bits
  wire [9:0] level = {channel_select_q, 6'h2B};
  // comparator is noise while not holding
  always @(posedge ref_clk) junk_q <= ~junk_q;
  // comparator answer
  assign compare_high = sample_hold_q ? (level >= trial_code_q) : junk_q;
endmodule // adc_core_model
`default_nettype wire

// ==== adc_config_and_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
// ***********
// testbench
// ***********
module adc_config_and_sequencer_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sleep_req = 1'b0;
  wire [7:0] reg_rdata_q;
  wire compare_high;
  wire [3:0] channel_select_q;
  wire [9:0] trial_code_q;
  wire sample_hold_q;
  wire [1:0] reference_select_q;
  wire [15:0] pin_analog_q;
  wire irq_q;
  logic [7:0] rv;
  logic [9:0] lv;
  integer error_cnt = 0;
  integer total_checks = 0;
  integer n;
  integer k;
  adc_config_and_sequencer adc_config_and_sequencer_inst (.*);
  adc_core_model adc_core_model_inst (.*);
  // clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // compare one value
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      error_cnt = error_cnt + 1;
    end
  endtask
  // bus cycles, ending at the falling edge
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(negedge ref_clk);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata_q;
  endtask
  // wait out a conversion, n gets its length
  task hold_len;
    n = 0;
    while (sample_hold_q !== 1'b1 && n < 5) @(negedge ref_clk) n = n + 1;
    n = 0;
    while (sample_hold_q !== 1'b0 && n < 3000) @(negedge ref_clk) n = n + 1;
    if (n >= 3000)
    begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
    else
      repeat (3) @(negedge ref_clk);
  endtask
  // bit period per clock code
  function automatic integer per(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return `RC_DIV_CYCLES;
    endcase
  endfunction
  // main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk(pin_analog_q, 16'hFFFF);
    for (k = 0; k < 3; k = k + 1)
    begin
      rd(k[3:0], rv);
      chk(rv, 8'h00);
    end
    rd(4'hF, rv);
    chk(rv, 8'h00);
    for (k = 0; k < 16; k = k + 1)
    begin
      wr(`OFS_REF_PIN, {2'h3, k[1:0], k[3:0]});
      @(negedge ref_clk);
      chk(pin_analog_q, k[3:0] == 0 ? 16'hFFFF : 16'hFFFF >> (k + 1));
      chk(reference_select_q, k[1:0]);
      rd(`OFS_REF_PIN, rv);
      chk(rv, {2'h0, k[1:0], k[3:0]});
    end
    wr(`OFS_CLK_FMT, 8'hFF);
    rd(`OFS_CLK_FMT, rv);
    chk(rv, 8'h87);
    $display("registers done");
    for (k = 0; k < 8; k = k + 1)
    begin
      lv = {k[2:0], 1'b0, 6'h2B};
      @(posedge ref_clk) sleep_req <= (k == 7);
      wr(`OFS_IRQ_ENABLE, {7'h00, k != 3});
      wr(`OFS_CLK_FMT, {k[0], 4'h0, k[2:0]});
      wr(`OFS_CONTROL, {2'h0, k[2:0], 3'h3});
      hold_len;
      chk(n >= 11 * per(k[2:0]) && n <= 12 * per(k[2:0]) + 4, 1'b1);
      chk(irq_q, k != 3);
      rd(`OFS_CONTROL, rv);
      chk(rv, {2'h0, k[2:0], 3'h1});
      rd(`OFS_IRQ_STATUS, rv);
      chk(rv, 8'h01);
      rd(`OFS_RESULT_HIGH, rv);
      chk(rv, k[0] ? {6'h00, lv[9:8]} : lv[9:2]);
      rd(`OFS_RESULT_LOW, rv);
      chk(rv, k[0] ? lv[7:0] : {lv[1:0], 6'h00});
      wr(`OFS_IRQ_CLEAR, 8'h01);
      rd(`OFS_IRQ_STATUS, rv);
      chk(rv, 8'h00);
      chk(irq_q, 1'b0);
    end
    $display("conversions done");
    wr(`OFS_CLK_FMT, 8'h00);
    wr(`OFS_CONTROL, 8'h3F);
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(sample_hold_q, 1'b1);
    @(posedge ref_clk) sleep_req <= 1'b0;
    hold_len;
    lv = {4'hF, 6'h2B};
    rd(`OFS_RESULT_HIGH, rv);
    chk(rv, lv[9:2]);
    wr(`OFS_IRQ_CLEAR, 8'h01);
    wr(`OFS_CLK_FMT, 8'h02);
    wr(`OFS_CONTROL, 8'h07);
    repeat (50) @(posedge ref_clk);
    wr(`OFS_CONTROL, 8'h00);
    hold_len;
    rd(`OFS_IRQ_STATUS, rv);
    chk(rv, 8'h00);
    rd(`OFS_RESULT_HIGH, rv);
    chk(rv, lv[9:2]);
    wr(`OFS_CONTROL, 8'h03);
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk(sample_hold_q, 1'b0);
    rd(`OFS_CONTROL, rv);
    chk(rv, 8'h00);
    rd(`OFS_RESULT_HIGH, rv);
    chk(rv, lv[9:2]);
    $display("abort and reset done");
    give_verdict;
  end
endmodule // adc_config_and_sequencer_tb
`default_nettype wire
